/* File: nfc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module nfc_host
    import nfc_pkg::*;
#(
    parameter int POLL_LIMIT = 65535
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rstn,
    // user side
    input  wire logic                 reqValid,
    output logic                      reqReady,
    input  wire nfc_req_s             req,
    input  wire logic                 byteMode,
    input  wire logic                 standby,
    output logic                      doneValid,
    output logic [DATA_W-1:0]         doneData,
    output logic                      doneTimeout,
    // flash pins
    output nfc_pins_s                 pins,
    input  wire logic [DATA_W-1:0]    dqIn,
    output logic [DATA_W-1:0]         dqOut,
    output logic                      dqOeN,
    input  wire logic                 ready_busy_n_output
);
    // ======================================================
    // pin synchronisers: a ready/busy change counts when stages 2 and 3 agree; the data pins pass stage 3 unfiltered
    logic [2:0]        rbSync_reg;
    logic              rbStable_reg;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rbSync_reg   <= 3'h7;
            rbStable_reg <= 1'b1;
        end else begin
            rbSync_reg <= {rbSync_reg[1:0], ready_busy_n_output};
            if (rbSync_reg[1] == rbSync_reg[2])
                rbStable_reg <= rbSync_reg[2];
        end
    end

    logic [DATA_W-1:0] dqS1_reg, dqS2_reg, dqS3_reg;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dqS1_reg <= '0;
            dqS2_reg <= '0;
            dqS3_reg <= '0;
        end else begin
            dqS1_reg <= dqIn;
            dqS2_reg <= dqS1_reg;
            dqS3_reg <= dqS2_reg;
        end
    end

    // ======================================================
    // command sequencing
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_WSETUP, ST_WSTROBE, ST_WHOLD,
        ST_RSETUP, ST_RSTROBE, ST_POLL, ST_DONE
    } nfc_state_e;

    nfc_state_e        state_reg;
    nfc_req_s          cur_reg;
    logic [2:0]        step_reg;
    logic [2:0]        steps_reg;
    logic [7:0]        cnt_reg;
    logic [15:0]       poll_reg;
    logic              bypass_reg;
    logic              prevToggle_reg;
    logic              pollFirst_reg;
    logic              timedOut_reg;
    logic [ADDR_W-1:0] cycAddr;
    logic [DATA_W-1:0] cycData;

    // one entry of the unlock/command table per step
    function automatic logic [ADDR_W+7:0] seq_entry(
        input nfc_op_e op, input logic [2:0] idx, input logic byp,
        input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [ADDR_W-1:0] u1;
        logic [ADDR_W-1:0] u2;
        u1 = {{(ADDR_W-11){1'b0}}, UNLOCK_ADDR1};
        u2 = {{(ADDR_W-11){1'b0}}, UNLOCK_ADDR2};
        seq_entry = {u1, CMD_RESET};
        case (op)
            OP_PROGRAM: begin
                if (byp)
                    seq_entry = (idx == 3'd0) ? {u1, CMD_PROGRAM} : {a, d};
                else
                    case (idx)
                        3'd0: seq_entry = {u1, UNLOCK_DATA1};
                        3'd1: seq_entry = {u2, UNLOCK_DATA2};
                        3'd2: seq_entry = {u1, CMD_PROGRAM};
                        default: seq_entry = {a, d};
                    endcase
            end
            OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                case (idx)
                    3'd0, 3'd3: seq_entry = {u1, UNLOCK_DATA1};
                    3'd1, 3'd4: seq_entry = {u2, UNLOCK_DATA2};
                    3'd2: seq_entry = {u1, CMD_ERASE};
                    default: seq_entry = (op == OP_CHIP_ERASE) ? {u1, CMD_CHIP} : {a, CMD_SECTOR};
                endcase
            end
            OP_BYPASS: begin
                if (byp)
                    seq_entry = (idx == 3'd0) ? {a, CMD_BYP_EXIT1} : {a, CMD_BYP_EXIT2};
                else
                    case (idx)
                        3'd0: seq_entry = {u1, UNLOCK_DATA1};
                        3'd1: seq_entry = {u2, UNLOCK_DATA2};
                        default: seq_entry = {u1, CMD_BYPASS};
                    endcase
            end
            OP_SUSPEND: seq_entry = {a, CMD_SUSPEND};
            OP_RESUME:  seq_entry = {a, CMD_RESUME};
            default:    seq_entry = {a, CMD_RESET};
        endcase
    endfunction

    function automatic logic [2:0] seq_len(input nfc_op_e op, input logic byp);
        case (op)
            OP_PROGRAM:                    seq_len = byp ? 3'd2 : 3'd4;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: seq_len = 3'd6;
            OP_BYPASS:                     seq_len = byp ? 3'd2 : 3'd3;
            default:                       seq_len = 3'd1;
        endcase
    endfunction

    always_comb begin
        logic [ADDR_W+7:0] e;
        e = seq_entry(cur_reg.op, step_reg, bypass_reg, cur_reg.addr, cur_reg.data[7:0]);
        cycAddr = e[ADDR_W+7:8];
        cycData = {8'h00, e[7:0]};
        // program data keeps the full word in x16 mode
        if (cur_reg.op == OP_PROGRAM && step_reg == steps_reg - 3'd1 && !byteMode)
            cycData = cur_reg.data;
    end

    assign reqReady = (state_reg == ST_IDLE);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg      <= ST_RESET;
            cur_reg        <= '0;
            step_reg       <= 3'h0;
            steps_reg      <= 3'h1;
            cnt_reg        <= 8'h00;
            poll_reg       <= 16'h0000;
            bypass_reg     <= 1'b0;
            prevToggle_reg <= 1'b0;
            pollFirst_reg  <= 1'b0;
            timedOut_reg   <= 1'b0;
            doneValid      <= 1'b0;
            doneData       <= '0;
            doneTimeout    <= 1'b0;
        end else begin
            doneValid   <= 1'b0;
            doneTimeout <= 1'b0;
            case (state_reg)
                ST_RESET: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(RESET_CYC)) begin
                        cnt_reg    <= 8'h00;
                        bypass_reg <= 1'b0;
                        state_reg  <= (cur_reg.op == OP_RESET) ? ST_DONE : ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (reqValid) begin
                        cur_reg   <= req;
                        step_reg  <= 3'h0;
                        cnt_reg   <= 8'h00;
                        steps_reg <= seq_len(req.op, bypass_reg);
                        if (req.op == OP_RESET) begin
                            state_reg <= ST_RESET;
                        end else if (req.op == OP_READ) begin
                            state_reg <= ST_RSETUP;
                        end else begin
                            state_reg <= ST_WSETUP;
                        end
                    end
                end
                ST_WSETUP: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(SETUP_CYC - 1)) begin
                        cnt_reg   <= 8'h00;
                        state_reg <= ST_WSTROBE;
                    end
                end
                ST_WSTROBE: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(STROBE_CYC - 1)) begin
                        cnt_reg   <= 8'h00;
                        state_reg <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    if (step_reg == steps_reg - 3'd1) begin
                        poll_reg      <= 16'h0000;
                        pollFirst_reg <= 1'b1;
                        if (cur_reg.op == OP_BYPASS)
                            bypass_reg <= ~bypass_reg;
                        if (cur_reg.op == OP_PROGRAM || cur_reg.op == OP_CHIP_ERASE ||
                            cur_reg.op == OP_SECTOR_ERASE || cur_reg.op == OP_RESUME)
                            state_reg <= ST_POLL;
                        else
                            state_reg <= ST_DONE;
                    end else begin
                        step_reg  <= step_reg + 3'd1;
                        state_reg <= ST_WSETUP;
                    end
                end
                ST_RSETUP: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(READ_CYC + 3)) begin
                        doneData  <= byteMode ? {8'h00, dqS3_reg[7:0]} : dqS3_reg;
                        state_reg <= ST_DONE;
                    end
                end
                ST_POLL: begin
                    // status read: toggle bit stops toggling and ready pin high
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(READ_CYC + 3)) begin
                        cnt_reg        <= 8'h00;
                        poll_reg       <= poll_reg + 16'h0001;
                        prevToggle_reg <= dqS3_reg[TOGGLE_BIT];
                        pollFirst_reg  <= 1'b0;
                        if (!pollFirst_reg && rbStable_reg &&
                            prevToggle_reg == dqS3_reg[TOGGLE_BIT]) begin
                            doneData  <= dqS3_reg;
                            state_reg <= ST_DONE;
                        end else if (poll_reg == 16'(POLL_LIMIT)) begin
                            // a stuck operation shows as a timeout; a rejected one stops toggling and ends as a normal done
                            timedOut_reg <= 1'b1;
                            state_reg    <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    doneValid    <= 1'b1;
                    doneTimeout  <= timedOut_reg;
                    timedOut_reg <= 1'b0;
                    // a timed-out operation leaves the device busy, so pulse its reset pin
                    state_reg    <= timedOut_reg ? ST_RESET : ST_IDLE;
                end
                default: state_reg <= ST_RESET;
            endcase
        end
    end

    // ======================================================
    // pin drive, all from flip-flops
    logic inWrite;
    logic inRead;
    assign inWrite = (state_reg == ST_WSETUP) || (state_reg == ST_WSTROBE) || (state_reg == ST_WHOLD);
    assign inRead  = (state_reg == ST_RSETUP) || (state_reg == ST_POLL);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pins  <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, resetN: 1'b0, byteN: 1'b1, addr: '0};
            dqOut <= '0;
            dqOeN <= 1'b1;
        end else begin
            pins.resetN <= (state_reg != ST_RESET);
            pins.byteN  <= ~byteMode;
            pins.ceN    <= ~(inWrite || inRead) && standby;
            pins.weN    <= ~(state_reg == ST_WSTROBE);
            // strobe lifted between polls, else the toggle bit never advances
            pins.oeN    <= ~inRead || (state_reg == ST_POLL && cnt_reg == 8'(READ_CYC + 3));
            pins.addr   <= inWrite ? cycAddr : cur_reg.addr;
            dqOut       <= cycData;
            dqOeN       <= ~inWrite;
        end
    end
endmodule
`default_nettype wire

/* File: nfc_pkg.sv */
package nfc_pkg;
    // ======================================================
    // device geometry
    localparam int BYTE_COUNT      = 1048576;
    localparam int WORD_COUNT      = 524288;
    localparam int ADDR_W          = 20;
    localparam int DATA_W          = 16;
    // ======================================================
    // command codes and unlock addresses (word mode)
    localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
    localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_CHIP     = 8'h10;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam logic [7:0]  CMD_BYPASS   = 8'h20;
    localparam logic [7:0]  CMD_BYP_EXIT1 = 8'h90;
    localparam logic [7:0]  CMD_BYP_EXIT2 = 8'h00;
    localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;
    localparam logic [7:0]  CMD_RESUME   = 8'h30;
    localparam logic [7:0]  CMD_RESET    = 8'hf0;
    // ======================================================
    // bit positions of status
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;
    // ======================================================
    // bus cycle timing at 10 MHz
    localparam int CLK_NS       = 100;
    localparam int SETUP_NS     = 100;
    localparam int STROBE_NS    = 100;
    localparam int READ_NS      = 200;
    localparam int RESET_NS     = 500;
    localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC     = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_CYC    = (RESET_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
        OP_SUSPEND, OP_RESUME, OP_BYPASS, OP_RESET
    } nfc_op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        nfc_op_e           op;
    } nfc_req_s;

    typedef struct packed {
        logic              ceN;
        logic              weN;
        logic              oeN;
        logic              resetN;
        logic              byteN;
        logic [ADDR_W-1:0] addr;
    } nfc_pins_s;
endpackage

/* File: nfc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module nfc_checker
    import nfc_pkg::*;
(
    // clock and reset
    input wire logic      clock,
    input wire logic      rstn,
    // user side
    input wire logic      reqValid,
    input wire logic      reqReady,
    input wire logic      doneValid,
    input wire logic      doneTimeout,
    // flash pins
    input wire nfc_pins_s pins,
    input wire logic      dqOeN
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ==========
    // bus cycles
    chk_no_contention: assert property (!dqOeN |-> pins.oeN)
        else $error("data driven in read");
    chk_write_select: assert property (!pins.weN |-> !pins.ceN && pins.oeN)
        else $error("bad write select");
    chk_write_hold: assert property (!pins.weN |-> !dqOeN ##1 $stable(pins.addr))
        else $error("write not held");
    chk_strobe_single: assert property ($fell(pins.weN) |-> !$past(dqOeN) ##1 pins.weN)
        else $error("bad strobe");
    chk_read_select: assert property (!pins.oeN |-> !pins.ceN && pins.weN)
        else $error("bad read select");
    // ==========
    // user handshake
    chk_one_request: assert property (reqValid && reqReady |=> !reqReady [*2])
        else $error("second request taken");
    chk_done_single: assert property (doneValid |=> !doneValid)
        else $error("done too long");
    chk_timeout_done: assert property (doneTimeout |-> doneValid)
        else $error("timeout without done");
endmodule
bind nfc_host nfc_checker chk (.clock, .rstn, .reqValid, .reqReady, .doneValid, .doneTimeout, .pins, .dqOeN);
`default_nettype wire

/* File: nfc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter int         BUSY_CYC = 12,
    parameter logic       TOP_BOOT = 1'b1,
    parameter logic [6:0] PROT_SEC = 7'h7c
) (
    // timer clock
    input wire logic              clock,
    // bus pins and the hang control
    input wire nfc_pins_s         pins,
    input wire logic [DATA_W-1:0] dqOut,
    input wire logic              hang,
    // supply and protection controls, then the data and ready/busy outputs
    input wire logic              lowSupply,
    input wire logic              unprotect,
    output logic [DATA_W-1:0]     dqIn,
    output logic                  ready_busy_n_output
);
    logic [15:0] mem [logic [19:0]];
    logic [15:0] outVal = 16'h0000;
    logic [15:0] lastOut = 16'h0000;
    logic [2:0]  seq = 3'h0;
    logic        weD = 1'b1;
    logic        oeD = 1'b1;
    logic        bypass = 1'b0;
    logic        toggle = 1'b0;
    logic        pollBit = 1'b0;
    logic        drv;
    int          busy = 0;
    assign drv = !pins.ceN && !pins.oeN && pins.resetN;
    // released bus shows the inverse so a stale value cannot pass
    assign dqIn = drv ? outVal : ~lastOut;
    assign ready_busy_n_output = (busy == 0);
    function automatic logic [15:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    // boot end region splits into four small sectors, the others are one sector each
    function automatic logic [6:0] sec_of(input logic [19:0] a);
        logic [2:0] o;
        o = TOP_BOOT ? a[14:12] : ~a[14:12];
        if (a[19:15] != {5{TOP_BOOT}}) return {a[19:15], 2'd0};
        return {a[19:15], o[2] ? (o[1] ? 2'd3 : (o[0] ? 2'd2 : 2'd1)) : 2'd0};
    endfunction
    task automatic wipe(input logic all, input logic [6:0] s);
        foreach (mem[k]) if ((all || sec_of(k) == s) && (sec_of(k) != PROT_SEC || unprotect)) mem[k] = 16'hffff;
        busy <= BUSY_CYC;
        pollBit <= 1'b0;
    endtask
    task automatic cmd(input logic [19:0] a, input logic [7:0] d);
        logic u1;
        logic u2;
        u1 = (a[10:0] == UNLOCK_ADDR1);
        u2 = (a[10:0] == UNLOCK_ADDR2) && d == UNLOCK_DATA2;
        seq <= 3'h0;
        case (seq)
            3'h0: begin
                if (u1 && d == UNLOCK_DATA1) seq <= 3'h1;
                if (bypass && d == CMD_PROGRAM) seq <= 3'h3;
                if (bypass && d == CMD_BYP_EXIT1) seq <= 3'h6;
            end
            3'h1: if (u2) seq <= 3'h2;
            3'h2: begin
                if (u1 && d == CMD_PROGRAM) seq <= 3'h3;
                if (u1 && d == CMD_ERASE) seq <= 3'h4;
                if (u1 && d == CMD_BYPASS) bypass <= 1'b1;
            end
            3'h4: if (u1 && d == UNLOCK_DATA1) seq <= 3'h5;
            3'h5: if (u2) seq <= 3'h7;
            3'h6: if (d == CMD_BYP_EXIT2) bypass <= 1'b0;
            3'h7: if (d == CMD_CHIP || d == CMD_SECTOR) wipe(d == CMD_CHIP, sec_of(a));
            default: ;
        endcase
    endtask
    always @(posedge clock) begin
        weD <= pins.weN;
        oeD <= pins.oeN;
        outVal <= (busy > 0) ? {8'h00, pollBit, toggle, 6'h00} : rd(pins.addr);
        if (drv) lastOut <= dqIn;
        if (!pins.resetN) begin
            busy <= 0;
            seq <= 3'h0;
            bypass <= 1'b0;
        end else begin
            if (busy > 0 && !hang) busy <= busy - 1;
            if (pins.oeN && !oeD && busy > 0) toggle <= !toggle;
            if (pins.weN && !weD && !pins.ceN && busy == 0 && !lowSupply) begin
                if (seq == 3'h3) begin
                    if (sec_of(pins.addr) != PROT_SEC || unprotect) mem[pins.addr] = rd(pins.addr) & dqOut;
                    pollBit <= ~dqOut[7];
                    busy <= BUSY_CYC;
                    seq <= 3'h0;
                end else begin
                    cmd(pins.addr, dqOut[7:0]);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: nfc_host_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module nfc_host_bench
    import nfc_pkg::*;
();
    typedef struct {
        nfc_op_e     op;
        logic [19:0] a;
        logic [15:0] d;
    } nfc_row_s;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        reqValid = 1'b0;
    logic        byteMode = 1'b0;
    logic        standby = 1'b0;
    logic        hang = 1'b0;
    logic        lowSupply = 1'b0;
    logic        unprotect = 1'b0;
    nfc_req_s    req = '0;
    logic        reqReady, doneValid, doneTimeout, dqOeN, ready_busy_n_output;
    logic [15:0] doneData, dqIn, dqOut;
    nfc_pins_s   pins;
    int          miscompares = 0;
    int          n_compared = 0;
    // reads carry the expected word in d
    nfc_row_s rows [17] = '{'{OP_RESET, 20'h0, 16'h0}, '{OP_PROGRAM, 20'h10, 16'h1234},
        '{OP_READ, 20'h10, 16'h1234}, '{OP_PROGRAM, 20'h8010, 16'habcd}, '{OP_SECTOR_ERASE, 20'h0, 16'h0},
        '{OP_READ, 20'h10, 16'hffff}, '{OP_READ, 20'h8010, 16'habcd}, '{OP_BYPASS, 20'h0, 16'h0},
        '{OP_PROGRAM, 20'h20, 16'h5a5a}, '{OP_BYPASS, 20'h0, 16'h0}, '{OP_READ, 20'h20, 16'h5a5a},
        '{OP_PROGRAM, 20'hf8000, 16'h0}, '{OP_READ, 20'hf8000, 16'hffff}, '{OP_SUSPEND, 20'h0, 16'h0},
        '{OP_RESUME, 20'h0, 16'h0}, '{OP_CHIP_ERASE, 20'h0, 16'h0}, '{OP_READ, 20'h8010, 16'hffff}};
    always #50 clock = ~clock;
    nfc_host #(.POLL_LIMIT(8)) dut (.clock, .rstn, .reqValid, .reqReady, .req, .byteMode, .standby, .doneValid,
        .doneData, .doneTimeout, .pins, .dqIn, .dqOut, .dqOeN, .ready_busy_n_output);
    nfc_flash_model flash (.clock, .pins, .dqOut, .hang, .lowSupply, .unprotect, .dqIn, .ready_busy_n_output);
    task automatic end_of_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp16({15'h0, got}, {15'h0, exp});
    endtask
    // every wait is bounded; running out ends the run
    task automatic issue(input nfc_op_e op, input logic [19:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            end_of_test();
        end
        req = '{addr: a, data: d, op: op};
        reqValid = 1'b1;
        step(1);
        reqValid = 1'b0;
        while (doneValid !== 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
        if (n >= 3000) begin
            miscompares++;
            end_of_test();
        end
    endtask
    initial begin
        step(10);
        rstn = 1'b1;
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].a, rows[i].d);
            cmp1(doneTimeout, 1'b0);
            if (rows[i].op == OP_READ) cmp16(doneData, rows[i].d);
        end
        hang = 1'b1;
        issue(OP_PROGRAM, 20'h40, 16'h0001);
        cmp1(doneTimeout, 1'b1);
        hang = 1'b0;
        issue(OP_READ, 20'h8010, 16'h0);
        cmp16(doneData, 16'hffff);
        issue(OP_PROGRAM, 20'hfc010, 16'h2468);
        issue(OP_SECTOR_ERASE, 20'hfe000, 16'h0);
        issue(OP_READ, 20'hfc010, 16'h0);
        cmp16(doneData, 16'h2468);
        unprotect = 1'b1;
        issue(OP_PROGRAM, 20'hf8020, 16'h1111);
        unprotect = 1'b0;
        issue(OP_READ, 20'hf8020, 16'h0);
        cmp16(doneData, 16'h1111);
        lowSupply = 1'b1;
        issue(OP_PROGRAM, 20'h60, 16'h0);
        lowSupply = 1'b0;
        issue(OP_READ, 20'h60, 16'h0);
        cmp16(doneData, 16'hffff);
        byteMode = 1'b1;
        step(3);
        cmp1(pins.byteN, 1'b0);
        byteMode = 1'b0;
        standby = 1'b1;
        step(3);
        cmp1(pins.byteN, 1'b1);
        cmp1(pins.ceN, 1'b1);
        rstn = 1'b0;
        step(2);
        cmp1(pins.resetN, 1'b0);
        cmp1(dqOeN, 1'b1);
        rstn = 1'b1;
        standby = 1'b0;
        issue(OP_READ, 20'h8010, 16'h0);
        cmp16(doneData, 16'hffff);
        end_of_test();
    end
endmodule
`default_nettype wire
